// *** hdl/shr_pkg.sv ***
package shr_pkg;

	// System clock and reset timing
	localparam int unsigned CLK_SYS_MHZ = 100;
	localparam int unsigned CLK_SYS_NS = 10;
	localparam int unsigned RST_MIN_NS = 40;
	localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

	// Host bus rates
	localparam int unsigned I2C_STD_KBPS = 100;
	localparam int unsigned I2C_FAST_KBPS = 400;
	localparam int unsigned SPI_MAX_KBPS = 5000;
	localparam int unsigned I2C_OVERSAMPLE = 40;
	localparam int unsigned SPI_OVERSAMPLE = 16;

	// Bursts
	localparam int unsigned BURST_MAX = 64;

	// Address byte layout
	localparam logic [6:0] I2C_ADDR_BASE = 7'h30;
	localparam int unsigned I2C_RW_BIT = 0;
	localparam int unsigned SPI_RW_BIT = 7;
	localparam int unsigned SUB_REG_MSB = 6;
	localparam int unsigned SUB_REG_LSB = 3;
	localparam int unsigned SUB_CH_MSB = 2;
	localparam int unsigned SUB_CH_LSB = 1;

	// Channel codes and special registers
	localparam logic [1:0] CH_A = 2'h0;
	localparam logic [1:0] CH_B = 2'h1;
	localparam logic [3:0] REG_TX_FIFO = 4'h0;
	localparam logic [7:0] RD_RESERVED = 8'h00;

	// Strap classes of an address-select pin
	localparam logic [1:0] STRAP_VCC = 2'h0;
	localparam logic [1:0] STRAP_GND = 2'h1;
	localparam logic [1:0] STRAP_SCL = 2'h2;
	localparam logic [1:0] STRAP_SDA = 2'h3;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_SUB,
		I2C_WDATA,
		I2C_RDATA,
		I2C_WAIT
	} shr_i2c_st_t;

endpackage

// *** hdl/shr_spi_link.sv ***
`timescale 1ns/1ns
module shr_spi_link (
	input wire logic spi_sck,
	input wire logic link_rst_n,
	input wire logic spi_si,
	input wire logic [7:0] tx_byte,
	output logic spi_so,
	output logic [7:0] rx_byte,
	output logic rx_toggle
);

	typedef struct packed {
		logic [6:0] sh;
		logic [2:0] bitcnt;
		logic cmd_done;
		logic rd;
		logic [7:0] rx;
		logic tog;
	} shr_link_rx_t;

	typedef struct packed {
		logic so;
		logic [6:0] tx;
	} shr_link_tx_t;

	shr_link_rx_t r_reg;
	shr_link_rx_t r_next;
	shr_link_tx_t t_reg;
	shr_link_tx_t t_next;

	// Sample on the rising edge, byte complete after eight bits
	always_comb begin
		r_next = r_reg;
		r_next.sh = {r_reg.sh[5:0], spi_si};
		r_next.bitcnt = r_reg.bitcnt + 3'h1;
		if (r_reg.bitcnt == 3'h7) begin
			r_next.rx = {r_reg.sh, spi_si};
			r_next.tog = ~r_reg.tog;
			if (!r_reg.cmd_done) begin
				r_next.cmd_done = 1'b1;
				r_next.rd = r_reg.sh[shr_pkg::SPI_RW_BIT - 1];
			end
		end
	end

	// Shift out on the falling edge; in a read frame a new byte loads at each byte boundary after the command byte
	always_comb begin
		t_next.so = t_reg.tx[6];
		t_next.tx = {t_reg.tx[5:0], 1'b0};
		if (r_reg.cmd_done && r_reg.rd && r_reg.bitcnt == 3'h0) begin
			t_next.so = tx_byte[7];
			t_next.tx = tx_byte[6:0];
		end
	end

	// Frame end (select high) clears the link side
	always_ff @(posedge spi_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(negedge spi_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign spi_so = t_reg.so;
	assign rx_byte = r_reg.rx;
	assign rx_toggle = r_reg.tog;

endmodule

// *** hdl/shr_top.sv ***
`timescale 1ns/1ns
module shr_top #(
	parameter int unsigned CLK_MHZ = shr_pkg::CLK_SYS_MHZ,
	parameter int unsigned BURST_LEN = shr_pkg::BURST_MAX
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic if_sel_i2c,
	input wire logic scl_sck,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	input wire logic slave_addr_strap_lo_csn,
	input wire logic slave_addr_strap_hi_si,
	output logic spi_so,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_ch,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_fifo_full
);

	localparam logic [6:0] BURST_CNT = 7'(BURST_LEN);
	localparam logic [3:0] RST_CYC = 4'(shr_pkg::RST_MIN_CYC);

	// Rate, burst length and reset count checks
	if (CLK_MHZ * 1000 < shr_pkg::I2C_OVERSAMPLE * shr_pkg::I2C_FAST_KBPS) begin : g_chk_i2c
		$error("System clock too slow for fast-mode I2C");
	end
	if (CLK_MHZ * 1000 < shr_pkg::SPI_OVERSAMPLE * shr_pkg::SPI_MAX_KBPS) begin : g_chk_spi
		$error("System clock too slow for SPI read prefetch");
	end
	if (BURST_LEN < 1 || BURST_LEN > 126) begin : g_chk_burst
		$error("Burst length out of range");
	end
	if (shr_pkg::RST_MIN_CYC > 14) begin : g_chk_rst
		$error("Reset settle count too large");
	end

	typedef struct packed {
		logic [1:0] sel_sy;
		logic [1:0] scl_sy;
		logic scl_d;
		logic [1:0] sda_sy;
		logic sda_d;
		logic [1:0] lo_sy;
		logic [1:0] hi_sy;
		logic [1:0] csn_sy;
		logic [2:0] tog_sy;
		logic tog_d;
		logic [3:0] rst_cnt;
		logic mode_ok;
		logic mode_i2c;
		shr_pkg::shr_i2c_st_t st;
		logic [3:0] bitcnt;
		logic ack_ph;
		logic [7:0] sh;
		logic [3:0] i2c_reg;
		logic [1:0] i2c_ch;
		logic [2:0] flg_lo;
		logic [2:0] flg_hi;
		logic [6:0] spi_cnt;
		logic spi_rd;
		logic [3:0] spi_reg;
		logic [1:0] spi_ch;
		logic rd_pend;
		logic [7:0] rd_hold;
		logic wr;
		logic rd;
		logic ch;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic sda_oe;
		logic sda_out;
		logic spi_on;
	} shr_sys_t;

	shr_sys_t s_reg;
	shr_sys_t s_next;

	logic link_rst_n;
	logic [7:0] link_byte;
	logic link_tog;

	// Flags are {ever low, ever high, differs from SCL}
	function automatic logic [1:0] strap_code(input logic [2:0] f);
		logic [1:0] c;
		if (!f[2]) begin
			c = shr_pkg::STRAP_VCC;
		end else if (!f[1]) begin
			c = shr_pkg::STRAP_GND;
		end else if (!f[0]) begin
			c = shr_pkg::STRAP_SCL;
		end else begin
			c = shr_pkg::STRAP_SDA;
		end
		return c;
	endfunction

	function automatic logic ch_ok(input logic [1:0] c);
		return (c == shr_pkg::CH_A) || (c == shr_pkg::CH_B);
	endfunction

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic i2c_busy;
	logic [6:0] my_addr;
	logic [1:0] code_lo;
	logic [1:0] code_hi;
	logic tog_evt;

	assign scl_s = s_reg.scl_sy[1];
	assign sda_s = s_reg.sda_sy[1];
	assign scl_rise = scl_s & ~s_reg.scl_d;
	assign scl_fall = ~scl_s & s_reg.scl_d;
	assign i2c_start = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
	assign i2c_stop = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
	assign i2c_busy = (s_reg.st != shr_pkg::I2C_IDLE) && (s_reg.st != shr_pkg::I2C_WAIT);
	assign code_lo = strap_code(s_reg.flg_lo);
	assign code_hi = strap_code(s_reg.flg_hi);
	assign my_addr = shr_pkg::I2C_ADDR_BASE | {4'h0, code_hi[0], code_lo};
	assign tog_evt = s_reg.tog_sy[2] ^ s_reg.tog_d;

	always_comb begin
		s_next = s_reg;
		s_next.wr = 1'b0;
		s_next.rd = 1'b0;
		s_next.sda_out = 1'b0;
		s_next.sel_sy = {s_reg.sel_sy[0], if_sel_i2c};
		s_next.scl_sy = {s_reg.scl_sy[0], scl_sck};
		s_next.sda_sy = {s_reg.sda_sy[0], i2c_sda_in};
		s_next.lo_sy = {s_reg.lo_sy[0], slave_addr_strap_lo_csn};
		s_next.hi_sy = {s_reg.hi_sy[0], slave_addr_strap_hi_si};
		s_next.csn_sy = {s_reg.csn_sy[0], slave_addr_strap_lo_csn};
		s_next.tog_sy = {s_reg.tog_sy[1:0], link_tog};
		s_next.scl_d = scl_s;
		s_next.sda_d = sda_s;
		s_next.tog_d = s_reg.tog_sy[2];
		s_next.rd_pend = s_reg.rd;

		// Bus choice is caught once, after reset has settled
		if (!s_reg.mode_ok) begin
			if (s_reg.rst_cnt == RST_CYC) begin
				s_next.mode_ok = 1'b1;
				s_next.mode_i2c = s_reg.sel_sy[1];
				s_next.spi_on = ~s_reg.sel_sy[1];
			end else begin
				s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
			end
		end

		// Read data returns in the cycle after the read strobe
		if (s_reg.rd_pend) begin
			if (s_reg.mode_i2c) begin
				s_next.sh = reg_rdata;
			end else begin
				s_next.rd_hold = reg_rdata;
			end
		end

		// I2C slave, oversampled on the system clock
		if (s_reg.mode_ok && s_reg.mode_i2c) begin
			if (i2c_start) begin
				s_next.st = shr_pkg::I2C_ADDR;
				s_next.bitcnt = 4'h0;
				s_next.ack_ph = 1'b0;
				s_next.sda_oe = 1'b0;
				s_next.flg_lo = 3'h0;
				s_next.flg_hi = 3'h0;
			end else if (i2c_stop) begin
				s_next.st = shr_pkg::I2C_IDLE;
				s_next.sda_oe = 1'b0;
			end else if (i2c_busy) begin
				// Classify strap pins while the address byte runs
				if (s_reg.st == shr_pkg::I2C_ADDR && s_reg.bitcnt != 4'h8) begin
					s_next.flg_lo = s_reg.flg_lo | {~s_reg.lo_sy[1], s_reg.lo_sy[1],
						s_reg.lo_sy[1] ^ scl_s};
					s_next.flg_hi = s_reg.flg_hi | {~s_reg.hi_sy[1], s_reg.hi_sy[1],
						s_reg.hi_sy[1] ^ scl_s};
				end
				if (scl_rise) begin
					if (s_reg.bitcnt != 4'h8) begin
						s_next.bitcnt = s_reg.bitcnt + 4'h1;
						if (s_reg.st != shr_pkg::I2C_RDATA) begin
							s_next.sh = {s_reg.sh[6:0], sda_s};
						end
					end else if (s_reg.st == shr_pkg::I2C_RDATA && s_reg.ack_ph && !s_reg.sda_oe) begin
						if (sda_s) begin
							s_next.st = shr_pkg::I2C_WAIT;
						end else if (ch_ok(s_reg.i2c_ch)) begin
							s_next.rd = 1'b1;
							s_next.ch = s_reg.i2c_ch[0];
							s_next.addr = s_reg.i2c_reg;
						end else begin
							s_next.sh = shr_pkg::RD_RESERVED;
						end
					end
				end
				if (scl_fall) begin
					if (s_reg.bitcnt == 4'h8 && !s_reg.ack_ph) begin
						s_next.ack_ph = 1'b1;
						unique case (s_reg.st)
							shr_pkg::I2C_ADDR: begin
								if (s_reg.sh[7:1] == my_addr) begin
									s_next.sda_oe = 1'b1;
									if (s_reg.sh[shr_pkg::I2C_RW_BIT]) begin
										s_next.st = shr_pkg::I2C_RDATA;
										if (ch_ok(s_reg.i2c_ch)) begin
											s_next.rd = 1'b1;
											s_next.ch = s_reg.i2c_ch[0];
											s_next.addr = s_reg.i2c_reg;
										end else begin
											s_next.sh = shr_pkg::RD_RESERVED;
										end
									end else begin
										s_next.st = shr_pkg::I2C_SUB;
									end
								end else begin
									s_next.st = shr_pkg::I2C_WAIT;
								end
							end
							shr_pkg::I2C_SUB: begin
								s_next.i2c_reg = s_reg.sh[shr_pkg::SUB_REG_MSB:shr_pkg::SUB_REG_LSB];
								s_next.i2c_ch = s_reg.sh[shr_pkg::SUB_CH_MSB:shr_pkg::SUB_CH_LSB];
								s_next.sda_oe = 1'b1;
								s_next.st = shr_pkg::I2C_WDATA;
							end
							shr_pkg::I2C_WDATA: begin
								if (ch_ok(s_reg.i2c_ch) && s_reg.i2c_reg == shr_pkg::REG_TX_FIFO
									&& tx_fifo_full) begin
									s_next.st = shr_pkg::I2C_WAIT;
								end else begin
									s_next.sda_oe = 1'b1;
									if (ch_ok(s_reg.i2c_ch)) begin
										s_next.wr = 1'b1;
										s_next.ch = s_reg.i2c_ch[0];
										s_next.addr = s_reg.i2c_reg;
										s_next.wdata = s_reg.sh;
									end
								end
							end
							shr_pkg::I2C_RDATA: begin
								s_next.sda_oe = 1'b0;
							end
							default: begin
								s_next.sda_oe = 1'b0;
							end
						endcase
					end else if (s_reg.ack_ph) begin
						s_next.ack_ph = 1'b0;
						s_next.bitcnt = 4'h0;
						s_next.sda_oe = (s_reg.st == shr_pkg::I2C_RDATA) ? ~s_reg.sh[7] : 1'b0;
					end else if (s_reg.st == shr_pkg::I2C_RDATA && s_reg.bitcnt != 4'h0) begin
						s_next.sh = {s_reg.sh[6:0], 1'b0};
						s_next.sda_oe = ~s_reg.sh[6];
					end
				end
			end
		end

		// SPI side: bytes arrive from the link clock domain
		if (s_reg.mode_ok && !s_reg.mode_i2c) begin
			if (s_reg.csn_sy[1]) begin
				s_next.spi_cnt = 7'h00;
			end else if (tog_evt) begin
				if (s_reg.spi_cnt == 7'h00) begin
					s_next.spi_rd = link_byte[shr_pkg::SPI_RW_BIT];
					s_next.spi_reg = link_byte[shr_pkg::SUB_REG_MSB:shr_pkg::SUB_REG_LSB];
					s_next.spi_ch = link_byte[shr_pkg::SUB_CH_MSB:shr_pkg::SUB_CH_LSB];
					if (link_byte[shr_pkg::SPI_RW_BIT]) begin
						if (ch_ok(link_byte[shr_pkg::SUB_CH_MSB:shr_pkg::SUB_CH_LSB])) begin
							s_next.rd = 1'b1;
							s_next.ch = link_byte[shr_pkg::SUB_CH_LSB];
							s_next.addr = link_byte[shr_pkg::SUB_REG_MSB:shr_pkg::SUB_REG_LSB];
						end else begin
							s_next.rd_hold = shr_pkg::RD_RESERVED;
						end
					end
				end else if (s_reg.spi_rd) begin
					if (s_reg.spi_cnt < BURST_CNT && ch_ok(s_reg.spi_ch)) begin
						s_next.rd = 1'b1;
						s_next.ch = s_reg.spi_ch[0];
						s_next.addr = s_reg.spi_reg;
					end else begin
						s_next.rd_hold = shr_pkg::RD_RESERVED;
					end
				end else if (s_reg.spi_cnt <= BURST_CNT && ch_ok(s_reg.spi_ch)) begin
					s_next.wr = 1'b1;
					s_next.ch = s_reg.spi_ch[0];
					s_next.addr = s_reg.spi_reg;
					s_next.wdata = link_byte;
				end
				if (s_reg.spi_cnt <= BURST_CNT) begin
					s_next.spi_cnt = s_reg.spi_cnt + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Link side held in reset outside a frame and outside SPI mode
	assign link_rst_n = rstn & ~slave_addr_strap_lo_csn & s_reg.spi_on;

	shr_spi_link u_link (
		.spi_sck(scl_sck),
		.link_rst_n(link_rst_n),
		.spi_si(slave_addr_strap_hi_si),
		.tx_byte(s_reg.rd_hold),
		.spi_so(spi_so),
		.rx_byte(link_byte),
		.rx_toggle(link_tog)
	);

	assign i2c_sda_out = s_reg.sda_out;
	assign i2c_sda_oe = s_reg.sda_oe;
	assign reg_wr = s_reg.wr;
	assign reg_rd = s_reg.rd;
	assign reg_ch = s_reg.ch;
	assign reg_addr = s_reg.addr;
	assign reg_wdata = s_reg.wdata;

endmodule

// *** tb/shr_chk.sv ***
`timescale 1ns/1ns
module shr_chk (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic if_sel_i2c,
	input wire logic scl_sck,
	input wire logic slave_addr_strap_lo_csn,
	input wire logic tx_fifo_full,
	input wire logic i2c_sda_out,
	input wire logic i2c_sda_oe,
	input wire logic spi_so,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rst; disable iff (1'b0) !rstn |-> !(reg_wr | reg_rd | i2c_sda_oe | spi_so); endproperty
	a_rst: assert property (p_rst) else $error("output active in reset");
	property p_strobe; (reg_wr | reg_rd) |=> !(reg_wr | reg_rd); endproperty
	a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
	property p_od; !i2c_sda_out; endproperty
	a_od: assert property (p_od) else $error("data line driven high");
	property p_mode; if_sel_i2c ? !spi_so : !i2c_sda_oe; endproperty
	a_mode: assert property (p_mode) else $error("unselected bus active");
	property p_full; if_sel_i2c && reg_wr && reg_addr == shr_pkg::REG_TX_FIFO |-> !tx_fifo_full; endproperty
	a_full: assert property (p_full) else $error("write into full fifo");
	property p_ack; if_sel_i2c && reg_wr |-> ##[0:4] i2c_sda_oe; endproperty
	a_ack: assert property (p_ack) else $error("write without acknowledge");
	property p_hold; $rose(i2c_sda_oe) |=> i2c_sda_oe [*8]; endproperty
	a_hold: assert property (p_hold) else $error("data line pulse too short");
	property p_edge; $changed(i2c_sda_oe) |-> !scl_sck; endproperty
	a_edge: assert property (p_edge) else $error("data line moved with clock high");
	property p_idle; !if_sel_i2c && slave_addr_strap_lo_csn && $past(slave_addr_strap_lo_csn) |-> !spi_so;
	endproperty
	a_idle: assert property (p_idle) else $error("serial out active while deselected");
endmodule
bind shr_top shr_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .if_sel_i2c(if_sel_i2c),
	.scl_sck(scl_sck), .slave_addr_strap_lo_csn(slave_addr_strap_lo_csn),
	.tx_fifo_full(tx_fifo_full), .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe),
	.spi_so(spi_so), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr));

// *** tb/shr_host.sv ***
`timescale 1ns/1ns
module shr_host (
	output logic scl_sck,
	output logic sda_drv,
	input wire logic sda,
	output logic csn,
	output logic si,
	input wire logic so
);
	int half_ns = 1250;
	initial begin
		scl_sck = 1'b1;
		sda_drv = 1'b0;
		csn = 1'b1;
		si = 1'b0;
	end
	task automatic idle(input logic m);
		scl_sck = m;
	endtask
	task automatic i2c_cond(input logic stop);
		#20 sda_drv = stop;
		#(half_ns - 20) scl_sck = 1'b1;
		#(half_ns) sda_drv = !stop;
		#(half_ns) scl_sck = stop;
	endtask
	task automatic i2c_bit(input logic b, output logic r);
		#20 sda_drv = !b;
		#(half_ns - 20) scl_sck = 1'b1;
		r = sda;
		#(half_ns) scl_sck = 1'b0;
	endtask
	task automatic i2c_byte(input logic [7:0] b, input logic mack, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
		i2c_bit(!mack, ack);
		ack = !ack;
	endtask
	task automatic spi_begin;
		scl_sck = 1'b0;
		#7 csn = 1'b0;
		#64;
	endtask
	task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			#32 scl_sck = 1'b1;
			r[i] = so;
			#(i == 0 ? 320 : 32) scl_sck = 1'b0;
		end
	endtask
	task automatic spi_end;
		#64 csn = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] DEV = 8'h60;
	logic clk_sys, rstn, sel, full;
	logic [1:0] hi_c, lo_c;
	logic [7:0] rdata;
	logic [7:0] rx [8];
	logic [12:0] wq [$];
	int errors, compares, cyc, nrd;
	function automatic logic strap(input logic [1:0] c, input logic s, input logic d);
		return c == 2'h0 ? 1'b1 : c == 2'h1 ? 1'b0 : c == 2'h2 ? s : d;
	endfunction
	function automatic logic [7:0] pat(input logic c, input logic [3:0] a);
		return {3'h0, c, a} ^ 8'hA5;
	endfunction
	wire scl, sda_drv, csn, si, so, sda_out, sda_oe, wr, rd, ch;
	wire [3:0] ra;
	wire [7:0] wd;
	wire sda = !(sda_drv | sda_oe);
	wire lo = sel ? strap(lo_c, scl, sda) : csn;
	wire hi = sel ? strap(hi_c, scl, sda) : si;
	shr_top #(.BURST_LEN(4)) dut (.clk_sys(clk_sys), .rstn(rstn), .if_sel_i2c(sel),
		.scl_sck(scl), .i2c_sda_in(sda), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
		.slave_addr_strap_lo_csn(lo), .slave_addr_strap_hi_si(hi), .spi_so(so), .reg_wr(wr),
		.reg_rd(rd), .reg_ch(ch), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rdata),
		.tx_fifo_full(full));
	shr_host host (.scl_sck(scl), .sda_drv(sda_drv), .sda(sda), .csn(csn), .si(si), .so(so));
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		#1 rdata = pat(ch, ra);
		cyc++;
		if (cyc == 95000) begin
			errors++;
			end_of_test;
		end
	end
	always @(negedge clk_sys) begin
		if (wr === 1'b1) wq.push_back({ch, ra, wd});
		if (rd === 1'b1) nrd++;
	end
	task automatic do_reset(input logic m, input int n);
		@(posedge clk_sys);
		#1 rstn = 1'b0;
		sel = m;
		host.idle(m);
		repeat (n) @(posedge clk_sys);
		#1 rstn = 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
	endtask
	task automatic t_strap;
		logic [7:0] a, r;
		logic k;
		for (int i = 0; i < 9; i++) begin
			hi_c = i[1:0];
			lo_c = i[2:1];
			a = {4'h6, hi_c[0], lo_c, 1'b0} ^ {6'h0, i == 8, 1'b0};
			host.i2c_cond(1'b0);
			host.i2c_byte(a, 1'b0, r, k);
			host.i2c_cond(1'b1);
			compare(k, i < 8);
		end
		hi_c = 2'h0;
		lo_c = 2'h0;
	endtask
	task automatic i2c_wr(input logic [7:0] sub, output logic [3:0] ak);
		logic [7:0] r;
		host.i2c_cond(1'b0);
		host.i2c_byte(DEV, 1'b0, r, ak[3]);
		host.i2c_byte(sub, 1'b0, r, ak[2]);
		host.i2c_byte(8'h3C, 1'b0, r, ak[1]);
		host.i2c_byte(8'hC3, 1'b0, r, ak[0]);
		host.i2c_cond(1'b1);
	endtask
	task automatic t_wr;
		logic [7:0] subs [3] = '{8'h02, 8'h00, 8'h1C};
		logic [3:0] ak;
		for (int c = 0; c < 3; c++) begin
			wq.delete();
			full = (c == 1);
			i2c_wr(subs[c], ak);
			compare(ak, c == 1 ? 4'hC : 4'hF);
			compare(wq.size(), c == 0 ? 2 : 0);
			if (c == 0) begin
				compare(wq[0], {1'b1, 4'h0, 8'h3C});
				compare(wq[1], {1'b1, 4'h0, 8'hC3});
			end
		end
		full = 1'b0;
	endtask
	task automatic t_rd;
		logic [7:0] r0, r1;
		logic [4:0] ak;
		int n0;
		n0 = nrd;
		host.i2c_cond(1'b0);
		host.i2c_byte(DEV, 1'b0, r0, ak[4]);
		host.i2c_byte(8'h2A, 1'b0, r0, ak[3]);
		host.i2c_cond(1'b0);
		host.i2c_byte(DEV | 8'h01, 1'b0, r0, ak[2]);
		host.i2c_byte(8'hFF, 1'b1, r0, ak[1]);
		host.i2c_byte(8'hFF, 1'b0, r1, ak[0]);
		host.i2c_cond(1'b1);
		compare(ak[4:2], 3'h7);
		compare(r0, pat(1'b1, 4'h5));
		compare(r1, pat(1'b1, 4'h5));
		compare(nrd - n0, 2);
	endtask
	task automatic t_std;
		logic [7:0] r;
		logic k;
		host.half_ns = 5000;
		host.i2c_cond(1'b0);
		host.i2c_byte(DEV, 1'b0, r, k);
		host.i2c_cond(1'b1);
		host.half_ns = 1250;
		compare(k, 1'b1);
	endtask
	task automatic spi_run(input logic [7:0] cmd, input int n);
		logic [7:0] r;
		host.spi_begin;
		host.spi_byte(cmd, r);
		for (int j = 0; j < n; j++) host.spi_byte(8'h10 + j[7:0], rx[j]);
		host.spi_end;
	endtask
	task automatic t_spi;
		int n0;
		wq.delete();
		spi_run(8'h2A, 5);
		compare(wq.size(), 4);
		for (int j = 0; j < 4; j++) compare(wq[j], {1'b1, 4'h5, 8'h10 + j[7:0]});
		n0 = nrd;
		spi_run(8'hAA, 2);
		compare(rx[0], pat(1'b1, 4'h5));
		compare(rx[1], pat(1'b1, 4'h5));
		compare(nrd - n0, 3);
		n0 = nrd;
		spi_run(8'h9C, 1);
		compare(rx[0], shr_pkg::RD_RESERVED);
		compare(wq.size(), 4);
		compare(nrd - n0, 0);
	endtask
	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		sel = 1'b1;
		full = 1'b0;
		hi_c = 2'h0;
		lo_c = 2'h0;
		rdata = 8'h00;
		errors = 0;
		compares = 0;
		cyc = 0;
		nrd = 0;
		do_reset(1'b1, 8);
		t_strap;
		t_wr;
		t_rd;
		t_std;
		do_reset(1'b0, 5);
		t_spi;
		end_of_test;
	end
endmodule
